// ===== design/drum_test_pkg.sv
// constants, codes and carrier types of the drum test-mode sequencer
package drum_test_pkg;
  // function word layout
  localparam int FW_W = 30;
  localparam int FW_CODE_LSB = 24;
  localparam int FW_CODE_W = 6;
  localparam int FW_FORCE_BIT = 23;
  localparam logic [5:0] CODE_PATTERN = 6'h0B;
  localparam logic [5:0] CODE_PARITY = 6'h0C;
  localparam logic [5:0] CODE_FAULT = 6'h0D;
  localparam logic [5:0] CODE_SHUTDOWN = 6'h0E;
  localparam logic [5:0] CODE_MASTER_CLEAR = 6'h01;
  localparam logic [5:0] CODE_RW_TERMINATE = 6'h02;
  // pattern test geometry
  localparam int NUM_PATTERNS = 8;
  localparam int LAST_TRACK = 383;
  localparam logic [1:0] PH_WRITE = 2'h0;
  localparam logic [1:0] PH_NORMAL = 2'h1;
  localparam logic [1:0] PH_LOW = 2'h2;
  localparam logic [1:0] PH_HIGH = 2'h3;
  // drum clock train, in bit times
  localparam int WORD_SPACING = 32;
  localparam int LAST_WORD = 1249;
  localparam int GAP_MIN = 16;
  localparam int GAP_MAX = 48;
  localparam int TACH_GUARD = 8;
  localparam int PARITY_BITS = 16;
  // bit period and mclk period, in ns
  localparam real BIT_PERIOD_NS = 312.8;
  localparam real BIT_TOL = 0.01;
  localparam real BIT_SLOP_NS = 50.0;
  localparam real MCLK_NS = 10.0;
  localparam int REV_BITS = LAST_WORD * WORD_SPACING + GAP_MAX;
  // longest revolution in mclk cycles, rounded up, used as watchdog
  localparam int REV_TIMEOUT_CYCLES =
    int'($ceil((REV_BITS * BIT_PERIOD_NS * (1.0 + BIT_TOL) + BIT_SLOP_NS) / MCLK_NS));
  // simulated thermal shutdown delay
  localparam real SHUTDOWN_DELAY_S = 3.0;
  localparam int SHUTDOWN_CYCLES = int'($floor(SHUTDOWN_DELAY_S * 1.0E9 / MCLK_NS));
  localparam int LOOP_WAIT_CYCLES = 8;
  localparam int FAULT_WAIT_CYCLES = 8;
  localparam int STATUS_W = 30;

  typedef struct packed {
    logic [2:0] pattern;
    logic [1:0] phase;
    logic write_mode;
  } drum_ctl_t;

  typedef struct packed {
    logic timing_err;
    logic overflow;
    logic motor_off;
    logic power_cut;
    logic [5:0] faults;
  } status_t;
endpackage : drum_test_pkg

// ===== design/word_buffer.sv
// small valid/ready buffer holding error and loop words
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // handshake terms and pointer arithmetic
  always_comb begin
    in_ready = (count != (AW+1)'(DEPTH));
    out_valid = (count != '0);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1)) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1)) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    out_data = mem[rd_ptr];
  end

  // storage and pointers
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : word_buffer

// ===== design/drum_test_seq.sv
// drum access subunit test-mode sequencer with drum clock train checker
`timescale 1ns/1ps
module drum_test_seq
  import drum_test_pkg::*;
#(
  parameter int NUM_TRACKS = LAST_TRACK + 1,
  parameter int SHUTDOWN_DELAY = SHUTDOWN_CYCLES,
  parameter int REV_TIMEOUT = REV_TIMEOUT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fw_req,
  input wire logic [FW_W-1:0] fw_data,
  output logic fw_ack,
  output logic od_req,
  input wire logic od_ack,
  input wire logic [FW_W-1:0] od_data,
  output logic id_req,
  input wire logic id_ack,
  output logic [FW_W-1:0] id_data,
  output logic status_interrupt,
  input wire logic ei_ack,
  output logic [FW_W-1:0] ei_data,
  input wire logic forced_error_sw,
  input wire logic drum_clk,
  input wire logic drum_rst,
  input wire logic word_clk,
  input wire logic tach_clk,
  input wire logic err_strobe,
  input wire logic [FW_W-1:0] err_word,
  output drum_ctl_t drum_ctl,
  output logic [PARITY_BITS+1:0] loop_out,
  input wire logic [PARITY_BITS+1:0] loop_in,
  output logic fault_sim,
  output logic speed_err_sim,
  output logic temp_sim,
  output logic power_cut,
  input wire logic [5:0] drum_faults,
  input wire logic motor_off
);
  // ---------------- drum clock domain ----------------
  logic [10:0] word_num, next_word_num;
  logic [5:0] bit_cnt, next_bit_cnt;
  logic [5:0] tach_age, next_tach_age;
  logic tach_seen, next_tach_seen;
  logic rev_tgl, next_rev_tgl, terr_tgl, next_terr_tgl, err_tgl, next_err_tgl;
  logic [FW_W-1:0] err_hold, next_err_hold;

  // count bit times between word clocks and check train spacing
  always_comb begin
    next_word_num = word_num;
    next_bit_cnt = (bit_cnt == 6'h3F) ? bit_cnt : bit_cnt + 6'h01;
    next_tach_age = (tach_age == 6'h3F) ? tach_age : tach_age + 6'h01;
    next_tach_seen = tach_seen;
    next_rev_tgl = rev_tgl;
    next_terr_tgl = terr_tgl;
    next_err_tgl = err_tgl;
    next_err_hold = err_hold;
    if (tach_clk) begin
      next_tach_seen = 1'b1;
      next_tach_age = 6'h00;
      if (word_num != 11'(LAST_WORD) || bit_cnt < 6'(TACH_GUARD - 1)) begin
        next_terr_tgl = ~terr_tgl;
      end
    end
    if (word_clk) begin
      next_bit_cnt = 6'h00;
      if (tach_seen) begin
        next_word_num = 11'h001;
        next_rev_tgl = ~rev_tgl;
        next_tach_seen = 1'b0;
        if (bit_cnt < 6'(GAP_MIN - 1) || bit_cnt > 6'(GAP_MAX - 1)
            || tach_age < 6'(TACH_GUARD - 1)) begin
          next_terr_tgl = ~terr_tgl;
        end
      end else begin
        next_word_num = word_num + 11'h001;
        if (word_num != 11'h000 && (bit_cnt != 6'(WORD_SPACING - 1)
            || word_num == 11'(LAST_WORD))) begin
          next_terr_tgl = ~terr_tgl;
        end
      end
    end
    if (err_strobe) begin
      next_err_hold = err_word;
      next_err_tgl = ~err_tgl;
    end
  end

  // drum clock domain registers
  always_ff @(posedge drum_clk) begin
    if (drum_rst) begin
      word_num <= '0;
      bit_cnt <= '0;
      tach_age <= '0;
      tach_seen <= 1'b0;
      rev_tgl <= 1'b0;
      terr_tgl <= 1'b0;
      err_tgl <= 1'b0;
      err_hold <= '0;
    end else begin
      word_num <= next_word_num;
      bit_cnt <= next_bit_cnt;
      tach_age <= next_tach_age;
      tach_seen <= next_tach_seen;
      rev_tgl <= next_rev_tgl;
      terr_tgl <= next_terr_tgl;
      err_tgl <= next_err_tgl;
      err_hold <= next_err_hold;
    end
  end

  // ---------------- crossings into mclk ----------------
  logic [2:0] rev_s1, rev_s2, rev_s3;
  logic [PARITY_BITS+1:0] loop_s1, loop_s2;
  logic [6:0] stat_s1, stat_s2;
  logic rev_evt, terr_evt, err_evt;

  // two-flop synchronisers, third stage only for toggle edge detect
  always_ff @(posedge mclk) begin
    rev_s1 <= {rev_tgl, terr_tgl, err_tgl};
    rev_s2 <= rev_s1;
    rev_s3 <= rev_s2;
    loop_s1 <= loop_in;
    loop_s2 <= loop_s1;
    stat_s1 <= {motor_off, drum_faults};
    stat_s2 <= stat_s1;
  end
  assign rev_evt = rev_s2[2] ^ rev_s3[2];
  assign terr_evt = rev_s2[1] ^ rev_s3[1];
  assign err_evt = rev_s2[0] ^ rev_s3[0];

  // ---------------- sequencer ----------------
  typedef enum logic [3:0] {
    S_IDLE, S_PT_RUN, S_PT_DRAIN, S_PAR_OD, S_PAR_LOOP, S_PAR_ID, S_FLT_WAIT,
    S_SD_SPEED, S_SD_TIMER, S_SD_HOLD, S_EI
  } state_t;

  state_t state, next_state, after_ei, next_after_ei;
  drum_ctl_t next_drum_ctl;
  logic [8:0] track, next_track;
  logic forced, next_forced;
  logic pend_rev, next_pend_rev, pend_err, next_pend_err;
  status_t status, next_status;
  logic [31:0] timer, next_timer;
  logic [FW_W-1:0] buf_a, next_buf_a, buf_b, next_buf_b, next_ei_data;
  logic [7:0] err_cnt, next_err_cnt;
  logic [PARITY_BITS+1:0] next_loop_out;
  logic next_fault_sim, next_speed_err_sim, next_temp_sim, next_power_cut;
  logic buf_in_valid, buf_in_ready, buf_out_valid;
  logic [FW_W-1:0] buf_in_data, buf_out_data, err_word_m;
  logic last_step, second_ei;
  logic next_second_ei;

  assign err_word_m = err_hold; // stable long after its toggle is seen
  assign last_step = (drum_ctl.pattern == 3'(NUM_PATTERNS - 1))
                     && (drum_ctl.phase == PH_HIGH) && (track == 9'(NUM_TRACKS - 1));

  // error words and the looped word pass through buffers A/B to the host
  word_buffer #(.WIDTH(FW_W), .DEPTH(2)) u_ab (
    .mclk(mclk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(id_ack),
    .out_data(buf_out_data)
  );
  assign id_req = buf_out_valid;
  assign id_data = buf_out_data;

  // next-state logic of the test sequencer
  always_comb begin
    next_state = state;
    next_after_ei = after_ei;
    next_drum_ctl = drum_ctl;
    next_track = track;
    next_forced = forced;
    next_pend_rev = pend_rev | rev_evt;
    next_pend_err = pend_err | err_evt;
    next_status = status;
    next_timer = (timer != 32'h0) ? timer - 32'h1 : timer;
    next_buf_a = buf_a;
    next_buf_b = buf_b;
    next_err_cnt = err_cnt;
    next_ei_data = ei_data;
    next_loop_out = loop_out;
    next_fault_sim = fault_sim;
    next_speed_err_sim = speed_err_sim;
    next_temp_sim = temp_sim;
    next_power_cut = power_cut;
    next_second_ei = second_ei;
    fw_ack = 1'b0;
    od_req = 1'b0;
    buf_in_valid = 1'b0;
    buf_in_data = err_word_m;
    case (state)
      S_IDLE: begin
        if (fw_req) begin
          fw_ack = 1'b1;
          next_status = '0;
          next_pend_rev = 1'b0;
          next_pend_err = 1'b0;
          next_drum_ctl = '{pattern: 3'h0, phase: PH_WRITE, write_mode: 1'b0};
          next_track = '0;
          next_timer = 32'(REV_TIMEOUT);
          next_second_ei = 1'b0;
          case (fw_data[FW_CODE_LSB +: FW_CODE_W])
            CODE_PATTERN: begin
              next_forced = forced_error_sw;
              next_drum_ctl.write_mode = 1'b1;
              next_state = S_PT_RUN;
            end
            CODE_PARITY: next_state = S_PAR_OD;
            CODE_FAULT: begin
              next_fault_sim = 1'b1;
              next_timer = 32'(FAULT_WAIT_CYCLES);
              next_state = S_FLT_WAIT;
            end
            CODE_SHUTDOWN: begin
              next_speed_err_sim = 1'b1;
              next_state = S_SD_SPEED;
            end
            default: next_state = S_IDLE;
          endcase
        end
      end
      S_PT_RUN: begin
        if (timer == 32'h0) begin
          next_status.timing_err = 1'b1;
          next_timer = 32'(REV_TIMEOUT);
        end
        if (pend_err) begin
          buf_in_valid = 1'b1;
          if (buf_in_ready) begin
            next_pend_err = err_evt;
          end
        end else if (pend_rev) begin
          // one revolution covers one track in the current phase
          if (forced && !last_step
              && (drum_ctl.phase == PH_LOW || drum_ctl.phase == PH_HIGH)) begin
            buf_in_valid = 1'b1;
            buf_in_data = {5'h00, drum_ctl.pattern, drum_ctl.phase, 11'h000, track};
          end
          if (buf_in_ready || !buf_in_valid) begin
            next_pend_rev = rev_evt;
            next_timer = 32'(REV_TIMEOUT);
            if (track != 9'(NUM_TRACKS - 1)) begin
              next_track = track + 9'h001;
            end else begin
              next_track = '0;
              next_drum_ctl.phase = drum_ctl.phase + 2'h1;
              next_drum_ctl.write_mode = (drum_ctl.phase == PH_HIGH);
              if (drum_ctl.phase == PH_HIGH) begin
                next_drum_ctl.pattern = drum_ctl.pattern + 3'h1;
              end
              if (last_step) begin
                next_drum_ctl.write_mode = 1'b0;
                next_state = S_PT_DRAIN;
              end
            end
          end
        end
      end
      S_PT_DRAIN: begin
        if (pend_err) begin
          buf_in_valid = 1'b1;
          if (buf_in_ready) begin
            next_pend_err = err_evt;
          end
        end else if (!buf_out_valid) begin
          next_ei_data = FW_W'(status);
          next_after_ei = S_IDLE;
          next_state = S_EI;
        end
      end
      S_PAR_OD: begin
        od_req = 1'b1;
        if (od_ack) begin
          next_buf_a = od_data;
          next_loop_out = {^od_data[15:8], od_data[15:8], ^od_data[7:0], od_data[7:0]};
          next_timer = 32'(LOOP_WAIT_CYCLES);
          next_state = S_PAR_LOOP;
        end
      end
      S_PAR_LOOP: begin
        if (timer == 32'h0) begin
          next_buf_b = {buf_a[FW_W-1:PARITY_BITS], loop_s2[16:9], loop_s2[7:0]};
          next_err_cnt = 8'(loop_s2[17] != ^loop_s2[16:9]) + 8'(loop_s2[8] != ^loop_s2[7:0]);
          next_state = S_PAR_ID;
        end
      end
      S_PAR_ID: begin
        buf_in_valid = !second_ei;
        buf_in_data = buf_b;
        if (buf_in_ready && !second_ei) begin
          next_second_ei = 1'b1;
        end
        if (second_ei && !buf_out_valid) begin
          next_ei_data = FW_W'(err_cnt);
          next_after_ei = S_IDLE;
          next_state = S_EI;
        end
      end
      S_FLT_WAIT: begin
        next_status.faults = stat_s2[5:0];
        if (timer == 32'h0) begin
          next_ei_data = FW_W'(next_status);
          next_fault_sim = 1'b0;
          next_after_ei = S_IDLE;
          next_state = S_EI;
        end
      end
      S_SD_SPEED: begin
        if (stat_s2[6]) begin
          next_status.motor_off = 1'b1;
          next_ei_data = FW_W'(next_status);
          next_after_ei = S_SD_TIMER;
          next_state = S_EI;
        end
      end
      S_SD_TIMER: begin
        next_temp_sim = 1'b1;
        if (!temp_sim) begin
          // delay runs from the thermal signal, not from the first interrupt
          next_timer = 32'(SHUTDOWN_DELAY);
        end else if (timer == 32'h0) begin
          next_power_cut = 1'b1;
          next_status.power_cut = 1'b1;
          next_ei_data = FW_W'(next_status);
          next_after_ei = S_SD_HOLD;
          next_state = S_EI;
        end
      end
      S_SD_HOLD: begin
        if (fw_req) begin
          fw_ack = 1'b1;
          if (fw_data[FW_FORCE_BIT] && (fw_data[FW_CODE_LSB +: FW_CODE_W] == CODE_MASTER_CLEAR
              || fw_data[FW_CODE_LSB +: FW_CODE_W] == CODE_RW_TERMINATE)) begin
            next_speed_err_sim = 1'b0;
            next_temp_sim = 1'b0;
            next_power_cut = 1'b0;
            next_state = S_IDLE;
          end
        end
      end
      S_EI: begin
        if (ei_ack) begin
          next_state = after_ei;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (buf_in_valid && !buf_in_ready && pend_err && err_evt) begin
      next_status.overflow = 1'b1;
    end
    // a train violation wins over the clear at a new function word
    if (terr_evt) begin
      next_status.timing_err = 1'b1;
    end
  end

  assign status_interrupt = (state == S_EI);

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
      after_ei <= S_IDLE;
      drum_ctl <= '0;
      track <= '0;
      forced <= 1'b0;
      pend_rev <= 1'b0;
      pend_err <= 1'b0;
      status <= '0;
      timer <= '0;
      buf_a <= '0;
      buf_b <= '0;
      err_cnt <= '0;
      ei_data <= '0;
      loop_out <= '0;
      fault_sim <= 1'b0;
      speed_err_sim <= 1'b0;
      temp_sim <= 1'b0;
      power_cut <= 1'b0;
      second_ei <= 1'b0;
    end else begin
      state <= next_state;
      after_ei <= next_after_ei;
      drum_ctl <= next_drum_ctl;
      track <= next_track;
      forced <= next_forced;
      pend_rev <= next_pend_rev;
      pend_err <= next_pend_err;
      status <= next_status;
      timer <= next_timer;
      buf_a <= next_buf_a;
      buf_b <= next_buf_b;
      err_cnt <= next_err_cnt;
      ei_data <= next_ei_data;
      loop_out <= next_loop_out;
      fault_sim <= next_fault_sim;
      speed_err_sim <= next_speed_err_sim;
      temp_sim <= next_temp_sim;
      power_cut <= next_power_cut;
      second_ei <= next_second_ei;
    end
  end
endmodule : drum_test_seq

// ===== verif/drum_test_seq_props.sv
// port assertions of the drum test-mode sequencer
`timescale 1ns/1ps
module drum_test_seq_props
  import drum_test_pkg::*;
#(
  parameter int SHUTDOWN_DELAY = 50
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fw_req,
  input wire logic fw_ack,
  input wire logic od_req,
  input wire logic od_ack,
  input wire logic id_req,
  input wire logic id_ack,
  input wire logic [FW_W-1:0] id_data,
  input wire logic status_interrupt,
  input wire logic ei_ack,
  input wire logic fault_sim,
  input wire logic temp_sim,
  input wire logic power_cut
);
  int temp_cnt;
  int next_temp_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles the thermal signal stood before the cut
  always_comb begin
    next_temp_cnt = (temp_sim && !power_cut) ? temp_cnt + 1 : 0;
  end
  always_ff @(posedge mclk) begin
    temp_cnt <= rst ? 0 : next_temp_cnt;
  end
  fw_pulse_a: assert property (fw_ack |-> fw_req ##1 !fw_ack)
    else $error("function ack not a single taken pulse");
  od_after_fw_a: assert property ($rose(od_req) |-> $past(fw_ack))
    else $error("data request without function word");
  od_drop_a: assert property (od_req && od_ack |=> !od_req)
    else $error("data request held after answer");
  id_hold_a: assert property (id_req && !id_ack |=> id_req && $stable(id_data))
    else $error("input word not held until taken");
  int_hold_a: assert property (status_interrupt && !ei_ack |=> status_interrupt)
    else $error("interrupt dropped before ack");
  int_drop_a: assert property (status_interrupt && ei_ack |=> !status_interrupt)
    else $error("interrupt stands after ack");
  int_drained_a: assert property ($rose(status_interrupt) |-> !id_req)
    else $error("interrupt raised with words pending");
  fault_only_a: assert property (fault_sim |-> !temp_sim)
    else $error("thermal line forced in fault test");
  cut_delay_a: assert property ($rose(power_cut) |-> temp_sim &&
    temp_cnt >= SHUTDOWN_DELAY - 2 && temp_cnt <= SHUTDOWN_DELAY + 2)
    else $error("power cut without thermal delay");
  cover property (fw_ack);
  cover property (od_req && od_ack);
  cover property ($rose(power_cut));
endmodule : drum_test_seq_props
bind drum_test_seq drum_test_seq_props #(.SHUTDOWN_DELAY(SHUTDOWN_DELAY)) props_i (
  .mclk, .rst, .fw_req, .fw_ack, .od_req, .od_ack, .id_req, .id_ack, .id_data,
  .status_interrupt, .ei_ack, .fault_sim, .temp_sim, .power_cut);

// ===== verif/drum_far_end.sv
// drum side model: short fake revolutions, data loop, status lines
`timescale 1ns/1ps
module drum_far_end (
  input wire logic drum_clk,
  input wire logic drum_rst,
  output logic word_clk,
  output logic tach_clk,
  input wire logic [17:0] loop_out,
  output logic [17:0] loop_in,
  input wire logic fault_sim,
  input wire logic speed_err_sim,
  input wire logic power_cut,
  output logic [5:0] drum_faults,
  output logic motor_off
);
  logic [4:0] pos;
  // shortened turn so a track passes quickly; tach 10 bits ahead of word one
  always_ff @(posedge drum_clk) begin
    pos <= (drum_rst || pos == 5'h17) ? 5'h00 : pos + 5'h01;
    tach_clk <= !drum_rst && pos == 5'h04;
    word_clk <= !drum_rst && pos == 5'h0E;
  end
  // data path and parity looped straight back
  assign loop_in = loop_out;
  // status lines follow the simulated causes
  assign drum_faults = fault_sim ? 6'h3F : 6'h00;
  assign motor_off = speed_err_sim | power_cut;
endmodule : drum_far_end

// ===== verif/tb.sv
// self-checking bench of the drum test-mode sequencer
`timescale 1ns/1ps
module tb;
  import drum_test_pkg::*;
  localparam int NT = 2;
  logic mclk = 0, drum_clk = 0, rst = 1, drum_rst = 1, sw = 0;
  logic fw_req = 0, od_ack = 0, id_ack = 0, ei_ack = 0;
  logic [FW_W-1:0] fw_data = 30'h0, od_data = 30'h0, id_data, ei_data;
  logic fw_ack, od_req, id_req, status_interrupt, word_clk, tach_clk;
  logic fault_sim, speed_err_sim, temp_sim, power_cut, motor_off;
  logic [17:0] loop_out, loop_in;
  logic [5:0] drum_faults;
  logic err_strobe = 0;
  logic [FW_W-1:0] err_word = 30'h15A5A5A5;
  drum_ctl_t drum_ctl;
  int miscompares = 0;
  int n_tests = 0;
  // clocks of the two domains
  always #5 mclk = ~mclk;
  always #24 drum_clk = ~drum_clk;
  drum_test_seq #(.NUM_TRACKS(NT), .SHUTDOWN_DELAY(50), .REV_TIMEOUT(2000)) uut (
    .mclk, .rst, .fw_req, .fw_data, .fw_ack, .od_req, .od_ack, .od_data,
    .id_req, .id_ack, .id_data, .status_interrupt, .ei_ack, .ei_data,
    .forced_error_sw(sw), .drum_clk, .drum_rst, .word_clk, .tach_clk,
    .err_strobe, .err_word, .drum_ctl, .loop_out, .loop_in,
    .fault_sim, .speed_err_sim, .temp_sim, .power_cut, .drum_faults, .motor_off);
  drum_far_end far (.drum_clk, .drum_rst, .word_clk, .tach_clk, .loop_out,
    .loop_in, .fault_sim, .speed_err_sim, .power_cut, .drum_faults, .motor_off);
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task chk(input string what, input logic [29:0] seen, input logic [29:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic sig(input int s);
    case (s)
      0: return fw_ack;
      1: return od_req;
      2: return id_req;
      default: return status_interrupt;
    endcase
  endfunction : sig
  // bounded wait for a handshake line, sampled after the falling edge
  task wt(input int s, input int lim);
    int i;
    logic ok;
    ok = 0;
    for (i = 0; i < lim && !ok; i++) begin
      #1 ok = (sig(s) === 1'b1);
      if (!ok) @(negedge mclk);
    end
    if (!ok) begin
      miscompares++;
      $display("[FAIL] wait %0d timed out", s);
      wrap_up();
    end
  endtask : wt
  task fw(input logic [5:0] code, input logic force_bit);
    @(negedge mclk);
    fw_data = {code, force_bit, 23'h0};
    fw_req = 1;
    wt(0, 20);
    @(negedge mclk);
    fw_req = 0;
  endtask : fw
  task ack_ei;
    @(negedge mclk);
    ei_ack = 1;
    @(negedge mclk);
    ei_ack = 0;
    @(negedge mclk);
    chk("interrupt drop", status_interrupt, 0);
  endtask : ack_ei
  task t_fault;
    fw(CODE_FAULT, 0);
    wt(3, 100);
    chk("fault status", ei_data[5:0], 6'h3F);
    chk("thermal off", temp_sim, 0);
    ack_ei();
  endtask : t_fault
  task t_parity;
    fw(CODE_PARITY, 0);
    wt(1, 20);
    @(negedge mclk);
    od_data = 30'h1234A5C3;
    od_ack = 1;
    @(negedge mclk);
    od_ack = 0;
    chk("one word asked", od_req, 0);
    chk("low byte", loop_out[7:0], 8'hC3);
    chk("high byte", loop_out[16:9], 8'hA5);
    wt(2, 100);
    repeat (5) @(negedge mclk);
    chk("count held back", status_interrupt, 0);
    chk("looped word", id_data, 30'h1234A5C3);
    id_ack = 1;
    @(negedge mclk);
    id_ack = 0;
    wt(3, 50);
    chk("error count", ei_data, 0);
    ack_ei();
  endtask : t_parity
  // host pops every error word as soon as it stands
  task t_pattern(input logic forced, input int exp);
    int n;
    int i;
    int steps;
    int bad;
    int wr;
    logic [2:0] last_pat;
    n = 0;
    steps = 0;
    bad = 0;
    wr = 0;
    last_pat = 3'h0;
    sw = forced;
    fw(CODE_PATTERN, 0);
    sw = 1;
    // without the switch, two detected error words come from the drum side
    if (!forced) begin
      repeat (2) begin
        @(negedge drum_clk);
        err_strobe = 1;
        @(negedge drum_clk);
        err_strobe = 0;
      end
      @(negedge mclk);
    end
    for (i = 0; i < 30000 && status_interrupt !== 1'b1; i++) begin
      id_ack = id_req;
      n += int'(id_req);
      if (id_req === 1'b1 && !forced) chk("error word", id_data, 30'h15A5A5A5);
      bad += int'(drum_ctl.write_mode && drum_ctl.phase != PH_WRITE);
      wr += int'(drum_ctl.write_mode);
      steps += int'(drum_ctl.pattern != last_pat);
      last_pat = drum_ctl.pattern;
      @(negedge mclk);
    end
    id_ack = 0;
    if (i == 30000) begin
      miscompares++;
      $display("[FAIL] pattern run timed out");
      wrap_up();
    end
    chk("drained", id_req, 0);
    chk("error words", n, exp);
    chk("write in read phase", bad, 0);
    chk("write phase seen", int'(wr > 0), 1);
    chk("pattern steps", steps, NUM_PATTERNS);
    ack_ei();
  endtask : t_pattern
  task t_shutdown(input logic [5:0] exit_code);
    fw(CODE_SHUTDOWN, 0);
    wt(3, 200);
    chk("speed error", speed_err_sim, 1);
    chk("no cut yet", power_cut, 0);
    ack_ei();
    wt(3, 200);
    chk("thermal", temp_sim, 1);
    chk("power cut", power_cut, 1);
    ack_ei();
    fw(CODE_FAULT, 0);
    repeat (20) @(negedge mclk);
    chk("hold ignores", fault_sim, 0);
    fw(exit_code, 1);
    repeat (5) @(negedge mclk);
    chk("released", {speed_err_sim, temp_sim, power_cut}, 3'h0);
  endtask : t_shutdown
  initial begin
    repeat (20) @(negedge mclk);
    rst = 0;
    drum_rst = 0;
    repeat (4) @(negedge mclk);
    t_fault();
    t_parity();
    t_pattern(1, NUM_PATTERNS * 2 * NT - 1);
    t_pattern(0, 2);
    t_shutdown(CODE_MASTER_CLEAR);
    t_fault();
    t_shutdown(CODE_RW_TERMINATE);
    t_parity();
    wrap_up();
  end
endmodule : tb
